//--- core/rsfo_pkg.sv
// Shared constants and types for the rotate/fill file-op datapath.
// Assumes a 32-bit Avalon-MM slave with byte addresses on a 6-bit port.
package rsfo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [5:0] RSFO_OFF_CTRL   = 6'h00;
    localparam logic [5:0] RSFO_OFF_INSTR  = 6'h04;
    localparam logic [5:0] RSFO_OFF_WREG   = 6'h08;
    localparam logic [5:0] RSFO_OFF_STATUS = 6'h0c;
    localparam logic [5:0] RSFO_OFF_BANK   = 6'h10;
    localparam logic [5:0] RSFO_OFF_INDEX  = 6'h14;
    localparam logic [5:0] RSFO_OFF_MADDR  = 6'h18;
    localparam logic [5:0] RSFO_OFF_MDATA  = 6'h1c;
    localparam logic [5:0] RSFO_OFF_STATE  = 6'h20;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int unsigned RSFO_MEM_AW      = 12;
    localparam int unsigned RSFO_BANK_W      = 4;
    localparam int unsigned RSFO_CTRL_EXT    = 0;
    localparam int unsigned RSFO_ST_ILLEGAL  = 0;
    localparam int unsigned RSFO_ST_RES_LSB  = 8;
    localparam int unsigned RSFO_ST_EA_LSB   = 16;

    ////////////////////////////////////////////////////////////////////////
    // Opcode patterns and addressing limits
    localparam logic [5:0] RSFO_ROT_OP6      = 6'h10;  // 010000
    localparam logic [6:0] RSFO_FILL_OP7     = 7'h34;  // 0110100
    localparam logic [7:0] RSFO_IDX_MAX      = 8'h5f;  // 95
    localparam logic [7:0] RSFO_FILL_VALUE   = 8'hff;
    localparam logic [3:0] RSFO_ACC_HI_BANK  = 4'hf;
    localparam logic [3:0] RSFO_ACC_LO_BANK  = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  RSFO_RST_BYTE    = 8'h00;
    localparam logic [15:0] RSFO_RST_INSTR   = 16'h0000;
    localparam logic [11:0] RSFO_RST_ADDR    = 12'h000;
    localparam logic [3:0]  RSFO_RST_BANK    = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_DECODE  = 5'b00010,
        ST_READ    = 5'b00100,
        ST_PROCESS = 5'b01000,
        ST_WRITE   = 5'b10000
    } rsfo_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b001,
        OP_ROT  = 3'b010,
        OP_FILL = 3'b100
    } rsfo_op_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } rsfo_flags_t;

    typedef struct packed {
        logic [5:0] op6;
        logic       dest;
        logic       acc;
        logic [7:0] faddr;
    } rsfo_instr_t;

endpackage

//--- core/rsfo_file_mem.sv
// Byte-wide data file memory with registered read data.
// Assumes one shared read/write address per cycle from the datapath.
module rsfo_file_mem
    import rsfo_pkg::*;
#(
    parameter int unsigned AW = RSFO_MEM_AW
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_nrst,
    // Access port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [7:0]    i_wdata,
    output logic [7:0]         o_rdata
);

    logic [7:0] mem_q [0:(1<<AW)-1];

    // Storage write
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
    end

    // Registered read, old data on a same-cycle write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= RSFO_RST_BYTE;
        end else begin
            o_rdata <= mem_q[i_addr];
        end
    end

endmodule

//--- core/rsfo_core.sv
// Rotate-right-no-carry and fill-ones datapath with Avalon-MM registers.
// Assumes a single clock, synchronous inputs, and a master that holds
// each request until it samples waitrequest low.
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - rotate right, bit 0 wraps to 7
// - rotate opcode 010000, d, a, f
// - rotate updates only N and Z
// - d=0 writes W, d=1 writes file
// - a=0 access bank, a=1 bank pointer
// - extended, a=0, f<=95 uses indexed offset
// - fill opcode 0110100, writes FFh, no flags
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
module rsfo_core
    import rsfo_pkg::*;
#(
    parameter int unsigned AW = RSFO_MEM_AW
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Avalon-MM slave
    input  wire logic [5:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [3:0]  i_byteenable,
    input  wire logic [31:0] i_writedata,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    rsfo_state_t           st_q;
    rsfo_op_t              op_q;
    rsfo_op_t              op_d;
    rsfo_instr_t           instr_q;
    rsfo_flags_t           status_q;
    logic                  ext_en_q;
    logic [7:0]            wreg_q;
    logic [RSFO_BANK_W-1:0] bank_q;
    logic [AW-1:0]         index_q;
    logic [AW-1:0]         maddr_q;
    logic [AW-1:0]         ea_q;
    logic [AW-1:0]         ea_d;
    logic [7:0]            result_q;
    logic                  illegal_q;
    logic                  wait_q;
    logic                  pend_q;
    logic                  mrd_q;
    logic [31:0]           rdata_q;
    logic [7:0]            mem_rdata;
    logic [31:0]           rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire req        = i_read | i_write;
    wire start      = req & wait_q & ~pend_q;
    wire commit     = req & ~wait_q;
    wire wr_commit  = commit & i_write;
    wire sel_ctrl   = (i_address == RSFO_OFF_CTRL);
    wire sel_instr  = (i_address == RSFO_OFF_INSTR);
    wire sel_wreg   = (i_address == RSFO_OFF_WREG);
    wire sel_status = (i_address == RSFO_OFF_STATUS);
    wire sel_bank   = (i_address == RSFO_OFF_BANK);
    wire sel_index  = (i_address == RSFO_OFF_INDEX);
    wire sel_maddr  = (i_address == RSFO_OFF_MADDR);
    wire sel_mdata  = (i_address == RSFO_OFF_MDATA);
    wire sel_state  = (i_address == RSFO_OFF_STATE);
    wire exec_go    = start & i_write & sel_instr;
    wire mem_rd_go  = start & i_read & sel_mdata;
    wire slow       = exec_go | mem_rd_go;
    wire done       = (st_q == ST_WRITE) | mrd_q;
    wire lane0      = i_byteenable[0];
    wire lane1      = i_byteenable[1];

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode and effective address
    wire is_rot  = (instr_q.op6 == RSFO_ROT_OP6);
    wire is_fill = ({instr_q.op6, instr_q.dest} == RSFO_FILL_OP7);
    wire idx_mode = ext_en_q & ~instr_q.acc
                  & (instr_q.faddr <= RSFO_IDX_MAX);
    wire [AW-1:0] idx_addr = AW'(index_q + AW'(instr_q.faddr));
    wire [AW-1:0] bank_addr = {bank_q, instr_q.faddr};
    wire [AW-1:0] acc_addr = instr_q.faddr[7]
                           ? {RSFO_ACC_HI_BANK, instr_q.faddr}
                           : {RSFO_ACC_LO_BANK, instr_q.faddr};

    assign op_d = is_rot ? OP_ROT : (is_fill ? OP_FILL : OP_NONE);
    assign ea_d = instr_q.acc ? bank_addr
                : (idx_mode ? idx_addr : acc_addr);

    ////////////////////////////////////////////////////////////////////////
    // Result and destination
    wire [7:0] rot_res = {mem_rdata[0], mem_rdata[7:1]};
    wire [7:0] res_d   = (op_q == OP_ROT) ? rot_res : RSFO_FILL_VALUE;
    wire in_write  = (st_q == ST_WRITE);
    wire to_wreg   = in_write & (op_q == OP_ROT) & ~instr_q.dest;
    wire to_file   = in_write & ((op_q == OP_FILL)
                   | ((op_q == OP_ROT) & instr_q.dest));

    ////////////////////////////////////////////////////////////////////////
    // File memory port sharing
    wire exec_mem        = (st_q == ST_READ) | in_write;
    wire [AW-1:0] m_addr = exec_mem ? ea_q : maddr_q;
    wire m_we = to_file | (wr_commit & sel_mdata & lane0);
    wire [7:0] m_wdata = in_write ? result_q : i_writedata[7:0];

    rsfo_file_mem #(
        .AW (AW)
    ) u_mem (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_we    (m_we),
        .i_addr  (m_addr),
        .i_wdata (m_wdata),
        .o_rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Readback selection
    wire [31:0] state_word = (32'(ea_q) << RSFO_ST_EA_LSB)
                           | (32'(result_q) << RSFO_ST_RES_LSB)
                           | (32'(illegal_q) << RSFO_ST_ILLEGAL);
    assign rd_mux = sel_ctrl   ? (32'(ext_en_q) << RSFO_CTRL_EXT)
                  : sel_instr  ? 32'(instr_q)
                  : sel_wreg   ? 32'(wreg_q)
                  : sel_status ? 32'(status_q)
                  : sel_bank   ? 32'(bank_q)
                  : sel_index  ? 32'(index_q)
                  : sel_maddr  ? 32'(maddr_q)
                  : sel_mdata  ? 32'(mem_rdata)
                  : sel_state  ? state_word
                  : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_q  <= 1'b1;
            pend_q  <= 1'b0;
            mrd_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            mrd_q <= mem_rd_go;
            if (start && slow) begin
                pend_q <= 1'b1;
            end else if (start) begin
                wait_q  <= 1'b0;
                rdata_q <= rd_mux;
            end else if (pend_q && done) begin
                pend_q  <= 1'b0;
                wait_q  <= 1'b0;
                rdata_q <= rd_mux;
            end else if (commit) begin
                wait_q <= 1'b1;
            end
        end
    end

    assign o_waitrequest = wait_q;
    assign o_readdata    = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_en_q <= 1'b0;
            bank_q   <= RSFO_RST_BANK;
            index_q  <= RSFO_RST_ADDR;
            maddr_q  <= RSFO_RST_ADDR;
        end else if (wr_commit) begin
            if (sel_ctrl && lane0) begin
                ext_en_q <= i_writedata[RSFO_CTRL_EXT];
            end
            if (sel_bank && lane0) begin
                bank_q <= i_writedata[RSFO_BANK_W-1:0];
            end
            if (sel_index && lane0) begin
                index_q[7:0] <= i_writedata[7:0];
            end
            if (sel_index && lane1) begin
                index_q[AW-1:8] <= i_writedata[AW-1:8];
            end
            if (sel_maddr && lane0) begin
                maddr_q[7:0] <= i_writedata[7:0];
            end
            if (sel_maddr && lane1) begin
                maddr_q[AW-1:8] <= i_writedata[AW-1:8];
            end
        end
    end

    // Working register and flags, hardware write first
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wreg_q   <= RSFO_RST_BYTE;
            status_q <= '0;
        end else if (in_write) begin
            if (to_wreg) begin
                wreg_q <= result_q;
            end
            if (op_q == OP_ROT) begin
                status_q.n <= result_q[7];
                status_q.z <= (result_q == RSFO_RST_BYTE);
            end
        end else if (wr_commit && lane0) begin
            if (sel_wreg) begin
                wreg_q <= i_writedata[7:0];
            end
            if (sel_status) begin
                status_q <= i_writedata[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle sequencer
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE:    st_q <= exec_go ? ST_DECODE : ST_IDLE;
                ST_DECODE:  st_q <= ST_READ;
                ST_READ:    st_q <= ST_PROCESS;
                ST_PROCESS: st_q <= ST_WRITE;
                ST_WRITE:   st_q <= ST_IDLE;
            endcase
        end
    end

    // Instruction, decode and result registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            instr_q   <= RSFO_RST_INSTR;
            op_q      <= OP_NONE;
            ea_q      <= RSFO_RST_ADDR;
            result_q  <= RSFO_RST_BYTE;
            illegal_q <= 1'b0;
        end else begin
            if (exec_go) begin
                instr_q <= i_writedata[15:0];
            end
            if (st_q == ST_DECODE) begin
                op_q      <= op_d;
                ea_q      <= ea_d;
                illegal_q <= (op_d == OP_NONE);
            end
            if (st_q == ST_PROCESS && op_q != OP_NONE) begin
                result_q <= res_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_rotate_result: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (st_q == ST_PROCESS && op_q == OP_ROT) |=>
        result_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("rotate result wrong");

    a_rotate_decode: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (st_q == ST_DECODE && instr_q[15:10] == RSFO_ROT_OP6) |=>
        op_q == OP_ROT)
        else $error("rotate opcode not decoded");

    a_rotate_flags: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (in_write && op_q == OP_ROT) |=>
        status_q.n == $past(result_q[7]) && $stable(status_q.c)
        && $stable(status_q.dc) && $stable(status_q.ov)
        && status_q.z == ($past(result_q) == '0))
        else $error("rotate flag update wrong");

    a_dest_select: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (in_write && op_q == OP_ROT) |->
        (m_we == instr_q.dest) ##1 (instr_q.dest || wreg_q == $past(result_q)))
        else $error("rotate destination wrong");

    a_bank_source: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (st_q == ST_DECODE && instr_q.acc) |=>
        ea_q == {bank_q, instr_q.faddr})
        else $error("banked address wrong");

    a_indexed_offset: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (st_q == ST_DECODE && !instr_q.acc && ext_en_q
         && instr_q.faddr <= RSFO_IDX_MAX) |=>
        ea_q == AW'(index_q + AW'(instr_q.faddr)))
        else $error("indexed address wrong");

    a_fill_ones: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (st_q == ST_PROCESS && op_q == OP_FILL) |=>
        result_q == RSFO_FILL_VALUE && m_we && m_addr == ea_q
        ##1 $stable(status_q))
        else $error("fill write wrong");

    a_four_phase: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        exec_go |=> st_q == ST_DECODE ##1 st_q == ST_READ
        ##1 st_q == ST_PROCESS ##1 st_q == ST_WRITE ##1 !wait_q)
        else $error("instruction cycle sequence wrong");

endmodule

//--- bench/rsfo_bus_master.sv
// Avalon-MM master standing in for the decode stage that issues words.
// Assumes a slave that answers each request with waitrequest low.
////////////////////////////////////////////////////////////////////////////
module rsfo_bus_master (
    // Clock
    input  wire logic        i_clk,
    // Slave answer
    input  wire logic [31:0] i_readdata,
    input  wire logic        i_waitrequest,
    // Request
    output logic [5:0]       o_address,
    output logic             o_read,
    output logic             o_write,
    output logic [3:0]       o_byteenable,
    output logic [31:0]      o_writedata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        o_address    = 6'h00;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_byteenable = 4'h0;
        o_writedata  = 32'h0;
    end

    // One transfer, held until waitrequest is sampled low; n = -1 on hang
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output int n);
        n = 0;
        @(posedge i_clk);
        o_address    <= a;
        o_read       <= !w;
        o_write      <= w;
        o_byteenable <= be;
        o_writedata  <= d;
        while (n >= 0) begin
            @(posedge i_clk);
            n++;
            if (i_waitrequest === 1'b0) break;
            if (n > 40) n = -1;
        end
        q = i_readdata;
        o_read  <= 1'b0;
        o_write <= 1'b0;
        // Released address and data show the inverse; byteenable keeps its last value
        o_address   <= ~a;
        o_writedata <= ~d;
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the rotate/fill datapath.
// Assumes the bus master model; all access goes over Avalon-MM.
////////////////////////////////////////////////////////////////////////////
module tb_top
    import rsfo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Bus and clocking
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [31:0] q;
    int          n;
    int          fails = 0;
    int          total_checks = 0;

    // Device and master
    rsfo_core dut (.i_clk(clk), .i_nrst(nrst), .i_address(address),
        .i_read(read), .i_write(write), .i_byteenable(byteenable),
        .i_writedata(writedata), .o_readdata(readdata),
        .o_waitrequest(waitrequest));
    rsfo_bus_master m (.i_clk(clk), .i_readdata(readdata),
        .i_waitrequest(waitrequest), .o_address(address), .o_read(read),
        .o_write(write), .o_byteenable(byteenable),
        .o_writedata(writedata));

    // 10 MHz clock
    initial begin
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        m.xfer(w, a, be, d, q, n);
        if (n < 0) begin
            fails++;
            $display("[ERR] %0t: bus timeout", $time);
            finish_test();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, 4'hf, d);
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hf, 32'h0);
        chk(q, exp);
    endtask

    task automatic mput(input logic [11:0] ad, input logic [7:0] b);
        wr(RSFO_OFF_MADDR, {20'h0, ad});
        wr(RSFO_OFF_MDATA, {24'h0, b});
    endtask

    task automatic mchk(input logic [11:0] ad, input logic [7:0] b);
        wr(RSFO_OFF_MADDR, {20'h0, ad});
        rchk(RSFO_OFF_MDATA, {24'h0, b});
    endtask

    // Execute one word; answer sampled at the sixth edge
    task automatic run(input logic [15:0] word);
        wr(RSFO_OFF_INSTR, {16'h0, word});
        chk(32'(n), 32'd6);
    endtask

    function automatic logic [15:0] rot(logic d, logic a, logic [7:0] f);
        return {RSFO_ROT_OP6, d, a, f};
    endfunction

    function automatic logic [15:0] fill(logic a, logic [7:0] f);
        return {RSFO_FILL_OP7, a, f};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rchk(RSFO_OFF_CTRL, 32'h0);
        rchk(RSFO_OFF_WREG, 32'h0);
        rchk(RSFO_OFF_STATUS, 32'h0);
        rchk(RSFO_OFF_BANK, 32'h0);
        rchk(RSFO_OFF_INDEX, 32'h0);
        rchk(RSFO_OFF_MADDR, 32'h0);
        rchk(RSFO_OFF_INSTR, 32'h0);
        rchk(RSFO_OFF_STATE, 32'h0);
        wr(6'h3c, 32'hffffffff);
        rchk(6'h3c, 32'h0);
        bus(1'b1, RSFO_OFF_INDEX, 4'h1, 32'hfff);
        rchk(RSFO_OFF_INDEX, 32'h0ff);
        wr(RSFO_OFF_INDEX, 32'h0);
    endtask

    task automatic t_rot_file;
        wr(RSFO_OFF_BANK, 32'h3);
        wr(RSFO_OFF_STATUS, 32'h0b);
        wr(RSFO_OFF_WREG, 32'h44);
        mput(12'h33a, 8'hd7);
        mput(12'h03a, 8'h11);
        run(rot(1'b1, 1'b1, 8'h3a));
        mchk(12'h33a, 8'heb);
        mchk(12'h03a, 8'h11);
        rchk(RSFO_OFF_WREG, 32'h44);
        rchk(RSFO_OFF_STATUS, 32'h1b);
        bus(1'b0, RSFO_OFF_STATE, 4'hf, 32'h0);
        chk({31'h0, q[0]}, 32'h0);
        chk({20'h0, q[27:16]}, 32'h33a);
        chk({24'h0, q[15:8]}, 32'heb);
    endtask

    task automatic t_rot_w;
        mput(12'hf85, 8'h01);
        run(rot(1'b0, 1'b0, 8'h85));
        rchk(RSFO_OFF_WREG, 32'h80);
        mchk(12'hf85, 8'h01);
        mput(12'h020, 8'h00);
        run(rot(1'b0, 1'b0, 8'h20));
        rchk(RSFO_OFF_WREG, 32'h00);
        rchk(RSFO_OFF_STATUS, 32'h0f);
    endtask

    task automatic t_ext;
        wr(RSFO_OFF_CTRL, 32'h1);
        wr(RSFO_OFF_INDEX, 32'h200);
        mput(12'h210, 8'h02);
        mput(12'h010, 8'h55);
        run(rot(1'b1, 1'b0, 8'h10));
        mchk(12'h210, 8'h01);
        mchk(12'h010, 8'h55);
        mput(12'h060, 8'h04);
        run(rot(1'b1, 1'b0, 8'h60));
        mchk(12'h060, 8'h02);
        rchk(RSFO_OFF_STATUS, 32'h0b);
        run(fill(1'b0, 8'h5f));
        mchk(12'h25f, 8'hff);
        wr(RSFO_OFF_CTRL, 32'h0);
    endtask

    task automatic t_fill;
        wr(RSFO_OFF_BANK, 32'h5);
        mput(12'h522, 8'h5a);
        run(fill(1'b1, 8'h22));
        mchk(12'h522, 8'hff);
        mput(12'hf90, 8'h00);
        run(fill(1'b0, 8'h90));
        mchk(12'hf90, 8'hff);
        rchk(RSFO_OFF_INSTR, {16'h0, fill(1'b0, 8'h90)});
        rchk(RSFO_OFF_STATUS, 32'h0b);
    endtask

    task automatic t_illegal;
        mput(12'h5aa, 8'h81);
        run({6'h11, 1'b1, 1'b1, 8'haa});
        mchk(12'h5aa, 8'h81);
        run(16'h0000);
        bus(1'b0, RSFO_OFF_STATE, 4'hf, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        chk({24'h0, q[15:8]}, 32'hff);
        rchk(RSFO_OFF_STATUS, 32'h0b);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_rot_file();
        t_rot_w();
        t_ext();
        t_fill();
        t_illegal();
        finish_test();
    end
endmodule
